// *** mps_pkg.sv ***
// package for the memory page select block: offsets, fields, reset values
// assumes a 10-bit word address and 16-bit data on the internal serial-port access path
`default_nettype none
package mps_pkg;
    localparam int          ADDR_W        = 10;
    localparam int          DATA_W        = 16;
    localparam logic [9:0]  SEL_ADDR      = 10'h3ff;   // page-select register
    localparam int          COMMON_BIT    = 8;
    localparam int          PICK_LSB      = 0;
    localparam int          PICK_W        = 3;
    localparam logic [15:0] SEL_RESET     = 16'h0000;
    localparam logic [15:0] SEL_MASK      = 16'h0107;  // writable bits
    localparam logic [15:0] COMMON_VALUE  = 16'h0100;
    localparam logic [2:0]  PICK_NONE     = 3'h0;
    localparam int          CRAM_DEPTH    = 1024;
    localparam int          CRAM_USABLE   = 1023;

    // number of code RAMs picked
    function automatic logic [1:0] mps_count(input logic [2:0] pick);
        mps_count = {1'b0, pick[0]} + {1'b0, pick[1]} + {1'b0, pick[2]};
    endfunction : mps_count
endpackage : mps_pkg
`default_nettype wire

// *** mps_cram.sv ***
// one code RAM, 1024 x 16, registered read data
// assumes the write strobe is a single-cycle pulse on ref_clk; read data is registered every cycle
`timescale 1ns/10ps
`default_nettype none
module mps_cram
#(
    parameter int DEPTH = 1024,
    parameter int AW    = 10,
    parameter int DW    = 16
)
(
    // clock
    input  wire logic          ref_clk,
    // access
    input  wire logic          wr,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    // a depth beyond the address range would leave words unreachable
    if (DEPTH > (1 << AW))
    begin : g_bad_depth
        $error("depth exceeds address space");
    end

    logic [DW-1:0] mem [DEPTH];

    // plain synchronous ram; no reset so it maps to block memory
    always_ff @(posedge ref_clk)
    begin
        if (wr)
            mem[addr] <= wdata;
        rdata <= mem[addr];
    end
endmodule : mps_cram
`default_nettype wire

// *** mps_page_select.sv ***
// memory page select: page-select register and routing of serial-port accesses
// assumes access strobes come from the serial-port logic on ref_clk, one cycle each
// Function
// [R1] top address always reaches page-select register
// [R2] host programs selection before target accesses
// [R3] nothing selected: ignore all but selection
// [R4] one-hot pick routes to one code RAM
// [R5] multi pick: broadcast write, no reads
// [R6] common bit set stores exactly 100000000
// [R7] common page exposes data RAMs, registers
// [R8] only 1023 code RAM words usable
// [R9] four bits, reset zero, never locked
// [R10] reserved bits ignore writes, read zero
`timescale 1ns/10ps
`default_nettype none
module mps_page_select
    import mps_pkg::*;
#(
    parameter int CHANNELS = 3
)
(
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    // access from the serial port
    input  wire logic                       acc_wr,
    input  wire logic                       acc_rd,
    input  wire logic [mps_pkg::ADDR_W-1:0] acc_addr,
    input  wire logic [mps_pkg::DATA_W-1:0] acc_wdata,
    output logic      [mps_pkg::DATA_W-1:0] acc_rdata,
    output logic                            acc_rvalid,
    output logic                            acc_ignored,
    // common page (data RAMs and registers)
    output logic                            common_wr,
    output logic                            common_rd,
    output logic      [mps_pkg::ADDR_W-1:0] common_addr,
    output logic      [mps_pkg::DATA_W-1:0] common_wdata,
    input  wire logic [mps_pkg::DATA_W-1:0] common_rdata,
    // selection state
    output logic                            common_page,
    output logic                            code_ram_one_pick,
    output logic                            code_ram_two_pick,
    output logic                            code_ram_three_pick
);
    // the pick field and the ram array are sized for three channels only
    if (CHANNELS != PICK_W)
    begin : g_bad_channels
        $error("pick field supports exactly three channels");
    end

    logic [DATA_W-1:0] page_sel;
    logic [PICK_W-1:0] code_ram_pick_field;
    logic              is_sel;
    logic              single;
    logic [PICK_W-1:0] cram_wr;
    logic [DATA_W-1:0] cram_rdata [PICK_W];
    logic              rd_cram;
    logic              rd_sel;
    logic              rd_common;
    logic [1:0]        rd_chan;
    logic [DATA_W-1:0] sel_hold;

    assign code_ram_pick_field = page_sel[PICK_LSB +: PICK_W];
    assign is_sel = (acc_addr == SEL_ADDR);                        // [R1]
    assign single = (mps_count(code_ram_pick_field) == 2'd1);

    // page-select register; writes always decoded, no lock input exists
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            page_sel <= SEL_RESET;                                 // [R9]
        else if (acc_wr && is_sel)                                 // [R1]
        begin
            if (acc_wdata[COMMON_BIT])
                page_sel <= COMMON_VALUE;                          // [R6]
            else
                page_sel <= acc_wdata & SEL_MASK;                  // [R10]
        end
    end

    // code RAM writes: the top word is never written, so 1023 words store data
    always_comb
    begin
        for (int i = 0; i < PICK_W; i++)
            cram_wr[i] = acc_wr && !is_sel && !page_sel[COMMON_BIT]
                         && code_ram_pick_field[i];                // [R4] [R5] [R8]
    end

    // the three code RAMs
    for (genvar g = 0; g < PICK_W; g++)
    begin : g_cram
        mps_cram #(.DEPTH(CRAM_DEPTH), .AW(ADDR_W), .DW(DATA_W)) u_cram
        (
            .ref_clk (ref_clk),
            .wr      (cram_wr[g]),
            .addr    (acc_addr),
            .wdata   (acc_wdata),
            .rdata   (cram_rdata[g])
        );
    end

    // common page strobes, registered so outputs come from flip-flops
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            common_wr    <= 1'b0;
            common_rd    <= 1'b0;
            common_addr  <= '0;
            common_wdata <= '0;
        end
        else
        begin
            common_wr    <= acc_wr && !is_sel && page_sel[COMMON_BIT];  // [R7]
            common_rd    <= acc_rd && !is_sel && page_sel[COMMON_BIT];  // [R7]
            common_addr  <= acc_addr;
            common_wdata <= acc_wdata;
        end
    end

    // read bookkeeping; a broadcast pick has no read path at all
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_cram   <= 1'b0;
            rd_sel    <= 1'b0;
            rd_common <= 1'b0;
            rd_chan   <= 2'd0;
            sel_hold  <= '0;
        end
        else
        begin
            rd_sel    <= acc_rd && is_sel;
            rd_cram   <= acc_rd && !is_sel && !page_sel[COMMON_BIT] && single;  // [R4] [R5]
            rd_common <= common_rd;
            rd_chan   <= code_ram_pick_field[2] ? 2'd2 :
                         (code_ram_pick_field[1] ? 2'd1 : 2'd0);
            sel_hold  <= page_sel;
        end
    end

    // read answer: selection and ram reads two cycles on, common page three cycles on
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            acc_rdata  <= '0;
            acc_rvalid <= 1'b0;
        end
        else
        begin
            acc_rvalid <= rd_sel || rd_cram || rd_common;
            if (rd_sel)
                acc_rdata <= sel_hold;
            else if (rd_cram)
                acc_rdata <= cram_rdata[rd_chan];
            else if (rd_common)
                acc_rdata <= common_rdata;
            else
                acc_rdata <= '0;
        end
    end

    // ignored flag: nothing selected, or a read during broadcast
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            acc_ignored <= 1'b0;
        else
            acc_ignored <= (acc_wr || acc_rd) && !is_sel && !page_sel[COMMON_BIT]
                           && ((code_ram_pick_field == PICK_NONE)             // [R3]
                               || (acc_rd && !single));                       // [R5]
    end

    // selection state mirrors for the rest of the device
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            common_page         <= 1'b0;
            code_ram_one_pick   <= 1'b0;
            code_ram_two_pick   <= 1'b0;
            code_ram_three_pick <= 1'b0;
        end
        else
        begin
            common_page         <= page_sel[COMMON_BIT];
            code_ram_one_pick   <= page_sel[0];
            code_ram_two_pick   <= page_sel[1];
            code_ram_three_pick <= page_sel[2];
        end
    end

    // a dropped access: flagged one cycle on and never passed to the common page
    sequence s_dropped;
        acc_ignored && !common_wr;
    endsequence

    a_sel_common: assert property (@(posedge ref_clk) disable iff (rst)  // [R6]
        acc_wr && is_sel && acc_wdata[COMMON_BIT] |=> page_sel == COMMON_VALUE)
        else $error("common write did not store the common value");

    a_sel_reserved: assert property (@(posedge ref_clk) disable iff (rst)  // [R10]
        (page_sel & ~SEL_MASK) == '0)
        else $error("reserved bits set");

    a_sel_write: assert property (@(posedge ref_clk) disable iff (rst)  // [R1]
        acc_wr && is_sel && !acc_wdata[COMMON_BIT]
        |=> page_sel == (($past(acc_wdata)) & SEL_MASK))
        else $error("selection write lost");

    a_none_ignored: assert property (@(posedge ref_clk) disable iff (rst)  // [R3]
        page_sel == SEL_RESET && acc_wr && !is_sel
        |-> cram_wr == '0 ##1 s_dropped)
        else $error("access not ignored with nothing selected");

    a_broadcast_wr: assert property (@(posedge ref_clk) disable iff (rst)  // [R5]
        acc_wr && !is_sel && !page_sel[COMMON_BIT] |-> cram_wr == code_ram_pick_field)
        else $error("broadcast write mismatch");

    a_broadcast_rd: assert property (@(posedge ref_clk) disable iff (rst)  // [R5]
        acc_rd && !is_sel && !page_sel[COMMON_BIT] && !single |-> ##2 !acc_rvalid)
        else $error("read answered during broadcast");

    // common read: strobe out one cycle on, model answers a cycle later, then registered
    a_common_route: assert property (@(posedge ref_clk) disable iff (rst)  // [R7]
        acc_rd && !is_sel && page_sel[COMMON_BIT] |-> ##3 acc_rvalid)
        else $error("common read not answered");

    a_top_protect: assert property (@(posedge ref_clk) disable iff (rst)  // [R8]
        is_sel |-> cram_wr == '0)
        else $error("top word written to code ram");

    a_sel_read: assert property (@(posedge ref_clk) disable iff (rst)  // [R1]
        acc_rd && is_sel |-> ##2 acc_rvalid && acc_rdata == $past(page_sel, 2))
        else $error("selection read wrong");

    a_single_rd: assert property (@(posedge ref_clk) disable iff (rst)  // [R4]
        acc_rd && !is_sel && !page_sel[COMMON_BIT] && single |-> ##2 acc_rvalid)
        else $error("single code ram read not answered");
endmodule : mps_page_select
`default_nettype wire

// *** mps_common_model.sv ***
// common page model: data RAMs and registers behind the page select block
// assumes single-cycle common_wr and common_rd pulses on ref_clk
`timescale 1ns/10ps
`default_nettype none
module mps_common_model
(
    // clock
    input  wire logic        ref_clk,
    // strobes, address and data from the page select block
    input  wire logic        common_wr,
    input  wire logic        common_rd,
    input  wire logic [9:0]  common_addr,
    input  wire logic [15:0] common_wdata,
    // read answer
    output logic      [15:0] common_rdata
);
    logic [15:0] mem [0:1023];
    // one store for every common-page address
    always_ff @(posedge ref_clk)
    begin
        if (common_wr)
            mem[common_addr] <= common_wdata;
    end
    // answer one cycle after the strobe; toggle otherwise so stale data cannot pass
    always @(posedge ref_clk)
    begin
        if (common_rd)
            common_rdata <= mem[common_addr];
        else
            common_rdata <= ~common_rdata;
    end
endmodule : mps_common_model
`default_nettype wire

// *** spi_memory_page_select_tb_top.sv ***
// testbench for the page select block: serial-port accesses against expected values
// assumes the common page model answers one cycle after common_rd
`timescale 1ns/10ps
`default_nettype none
module spi_memory_page_select_tb_top;
    import mps_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        acc_wr = 1'b0;
    logic        acc_rd = 1'b0;
    logic [9:0]  acc_addr = 10'h000;
    logic [15:0] acc_wdata = 16'h0000;
    logic [15:0] acc_rdata, common_wdata, common_rdata, mirror;
    logic        acc_rvalid, acc_ignored, common_wr, common_rd, common_page;
    logic        code_ram_one_pick, code_ram_two_pick, code_ram_three_pick;
    logic [9:0]  common_addr;
    logic [15:0] exp_mem [0:2];
    int          failures = 0;
    int          comparisons = 0;
    // selection outputs laid out as the register
    assign mirror = {7'h00, common_page, 5'h00, code_ram_three_pick, code_ram_two_pick,
                     code_ram_one_pick};
    always #25 ref_clk = ~ref_clk;
    mps_page_select u_dut (.ref_clk(ref_clk), .rst(rst), .acc_wr(acc_wr), .acc_rd(acc_rd),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .acc_rvalid(acc_rvalid), .acc_ignored(acc_ignored), .common_wr(common_wr),
        .common_rd(common_rd), .common_addr(common_addr), .common_wdata(common_wdata),
        .common_rdata(common_rdata), .common_page(common_page),
        .code_ram_one_pick(code_ram_one_pick), .code_ram_two_pick(code_ram_two_pick),
        .code_ram_three_pick(code_ram_three_pick));
    mps_common_model u_common (.ref_clk(ref_clk), .common_wr(common_wr),
        .common_rd(common_rd), .common_addr(common_addr), .common_wdata(common_wdata),
        .common_rdata(common_rdata));
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_flag
    task automatic finish_test();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    // one access; r picks read, ei says it must be dropped, ed is the read answer
    task automatic acc(input logic r, input logic [9:0] a, input logic [15:0] d,
                       input logic ei, input logic [15:0] ed);
        logic        ig;
        logic        v;
        logic [15:0] got;
        ig = 1'b0;
        v = 1'b0;
        got = 16'h0000;
        @(posedge ref_clk);
        acc_rd <= r;
        acc_wr <= !r;
        acc_addr <= a;
        acc_wdata <= d;
        // bounded answer window; a missing answer shows as a flag mismatch
        for (int k = 0; k < 5; k++)
        begin
            @(posedge ref_clk);
            if (k == 0)
            begin
                acc_rd <= 1'b0;
                acc_wr <= 1'b0;
            end
            #1;
            ig = ig | (acc_ignored === 1'b1);
            if (acc_rvalid === 1'b1)
            begin
                v = 1'b1;
                got = acc_rdata;
            end
        end
        chk_flag(ig, ei);
        chk_flag(v, r && !ei);
        if (r && !ei)
            chk_val(got, ed);
    endtask : acc
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        finish_test();
    end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        acc(1'b1, SEL_ADDR, 16'h0000, 1'b0, SEL_RESET);
        acc(1'b1, 10'h005, 16'h0000, 1'b1, 16'h0000);
        acc(1'b0, 10'h005, 16'h1234, 1'b1, 16'h0000);
        acc(1'b0, SEL_ADDR, 16'hffff, 1'b0, 16'h0000);
        acc(1'b1, SEL_ADDR, 16'h0000, 1'b0, COMMON_VALUE);
        chk_val(mirror, COMMON_VALUE);
        acc(1'b0, 10'h1ff, 16'h4321, 1'b0, 16'h0000);
        acc(1'b1, 10'h1ff, 16'h0000, 1'b0, 16'h4321);
        // each single pick gets its own word; 3ff stays the register (no RAM word)
        for (int i = 0; i < 3; i++)
        begin
            acc(1'b0, SEL_ADDR, 16'hfef8 | (16'h1 << i), 1'b0, 16'h0000);
            acc(1'b1, SEL_ADDR, 16'h0000, 1'b0, 16'h1 << i);
            chk_val(mirror, 16'h1 << i);
            exp_mem[i] = 16'ha000 + 16'(i);
            acc(1'b0, 10'h004, exp_mem[i], 1'b0, 16'h0000);
        end
        // every multi pick: broadcast write, dropped read, then per-RAM read back
        for (int p = 3; p < 8; p++)
        begin
            if (p == 4)
                continue;
            acc(1'b0, SEL_ADDR, 16'(p), 1'b0, 16'h0000);
            acc(1'b0, 10'h004, 16'h0b00 + 16'(p), 1'b0, 16'h0000);
            acc(1'b1, 10'h004, 16'h0000, 1'b1, 16'h0000);
            for (int i = 0; i < 3; i++)
            begin
                if (p[i])
                    exp_mem[i] = 16'h0b00 + 16'(p);
                acc(1'b0, SEL_ADDR, 16'h1 << i, 1'b0, 16'h0000);
                acc(1'b1, 10'h004, 16'h0000, 1'b0, exp_mem[i]);
            end
        end
        // second reset in mid-run returns the register to nothing selected
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        acc(1'b1, SEL_ADDR, 16'h0000, 1'b0, SEL_RESET);
        chk_val(mirror, SEL_RESET);
        acc(1'b1, 10'h004, 16'h0000, 1'b1, 16'h0000);
        finish_test();
    end
endmodule : spi_memory_page_select_tb_top
`default_nettype wire
